// ---- rtl/ifmt_master.sv ----
// host end: i2c master that sends frames and fetches waiting frames
`timescale 1ns/1ps
module ifmt_master #(
	parameter int QTR_CYC = ifmt_pkg::SCL_QTR_CYC
) (
	// system
	input  wire logic       CLK_SYS,
	input  wire logic       RESET_N,
	// link
	ifmt_link_if.host       LINK,
	// command frame out
	input  wire logic       WR_START,
	input  wire logic [7:0] WR_LEN,
	input  wire logic [7:0] WR_DATA,
	output logic            WR_TAKE,
	output logic            READY,
	// frame in
	output logic [7:0]      RD_DATA,
	output logic            RD_VALID,
	output logic [7:0]      RD_LEN,
	output logic            RD_DONE,
	output logic            NACK_ERR,
	output logic            BOOTED
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic sda_s1_ff, sda_s2_ff;
	logic attn_s1_ff, attn_s2_ff;
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			{sda_s1_ff, sda_s2_ff}   <= 2'h3;
			{attn_s1_ff, attn_s2_ff} <= 2'h0;
		end else begin
			{sda_s1_ff, sda_s2_ff}   <= {LINK.sda, sda_s1_ff};
			{attn_s1_ff, attn_s2_ff} <= {LINK.host_attention_line, attn_s1_ff};
		end
	end
	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	localparam logic [7:0] DIV_LAST = 8'(QTR_CYC - 1);
	ifmt_pkg::ifmt_mstate_t state_ff, nxt_state;
	ifmt_pkg::ifmt_kind_t   kind_ff, nxt_kind;
	logic [7:0] div_ff, nxt_div;
	logic [1:0] q_ff, nxt_q;
	logic [3:0] bit_ff, nxt_bit;
	logic [8:0] byte_ff, nxt_byte;
	logic [7:0] sh_ff, nxt_sh;
	logic       sda_oe_ff, nxt_sda_oe;
	logic       scl_oe_ff, nxt_scl_oe;
	logic [7:0] wlen_ff, nxt_wlen;
	logic [7:0] rlen_ff, nxt_rlen;
	logic       nacked_ff, nxt_nacked;
	logic       pend_ff, nxt_pend;
	logic       booted_ff, nxt_booted;
	logic [7:0] rd_data_ff, nxt_rd_data;
	logic       rd_valid_ff, nxt_rd_valid;
	logic       rd_done_ff, nxt_rd_done;
	logic       nack_ff, nxt_nack;
	logic       take_ff, nxt_take;
	logic       tick, is_wr, is_last, ready;

	// index of the final byte of a transfer, the address byte being index 0
	function automatic logic [8:0] last_idx(input ifmt_pkg::ifmt_kind_t k,
		input logic [7:0] wl, input logic [7:0] rl);
		unique case (k)
			ifmt_pkg::KIND_WR:  last_idx = {1'b0, wl} + 9'(ifmt_pkg::HDR_BYTES);
			ifmt_pkg::KIND_RDH: last_idx = 9'(ifmt_pkg::HDR_BYTES);
			default:            last_idx = {1'b0, rl};
		endcase
	endfunction

	assign tick    = (div_ff == DIV_LAST);
	assign is_wr   = (kind_ff == ifmt_pkg::KIND_WR) || (byte_ff == 9'h000);
	assign is_last = (byte_ff == last_idx(kind_ff, wlen_ff, rlen_ff));
	// writes wait for boot, for any pending frame and for a quiet attention line
	assign ready   = (state_ff == ifmt_pkg::M_IDLE) && !attn_s2_ff && !pend_ff
		&& booted_ff;

	always_comb begin
		nxt_state    = state_ff;
		nxt_kind     = kind_ff;
		nxt_div      = tick ? 8'h00 : div_ff + 8'h01;
		nxt_q        = q_ff;
		nxt_bit      = bit_ff;
		nxt_byte     = byte_ff;
		nxt_sh       = sh_ff;
		nxt_sda_oe   = sda_oe_ff;
		nxt_scl_oe   = scl_oe_ff;
		nxt_wlen     = wlen_ff;
		nxt_rlen     = rlen_ff;
		nxt_nacked   = nacked_ff;
		nxt_pend     = pend_ff;
		nxt_booted   = booted_ff;
		nxt_rd_data  = rd_data_ff;
		nxt_rd_valid = 1'b0;
		nxt_rd_done  = 1'b0;
		nxt_nack     = 1'b0;
		nxt_take     = 1'b0;
		unique case (state_ff)
			ifmt_pkg::M_IDLE: begin
				nxt_div    = 8'h00;
				nxt_q      = 2'h0;
				nxt_bit    = 4'h0;
				nxt_byte   = 9'h000;
				nxt_nacked = 1'b0;
				// a waiting frame always goes first, also one left from before reset
				if (attn_s2_ff) begin
					nxt_kind  = pend_ff ? ifmt_pkg::KIND_RDP : ifmt_pkg::KIND_RDH;
					nxt_sh    = ifmt_pkg::ADDR_RD;
					nxt_state = ifmt_pkg::M_START;
				end else if (WR_START && ready) begin
					nxt_kind  = ifmt_pkg::KIND_WR;
					nxt_wlen  = WR_LEN;
					nxt_sh    = ifmt_pkg::ADDR_WR;
					nxt_state = ifmt_pkg::M_START;
				end
			end
			ifmt_pkg::M_START: begin
				if (tick) begin
					nxt_q = q_ff + 2'h1;
					case (q_ff)
						2'h0: nxt_sda_oe = 1'b1;
						2'h2: nxt_scl_oe = 1'b1;
						2'h3: nxt_state = ifmt_pkg::M_BYTE;
						default: begin
						end
					endcase
				end
			end
			ifmt_pkg::M_BYTE: begin
				if (tick) begin
					nxt_q = q_ff + 2'h1;
					case (q_ff)
						2'h0: begin
							// ack slot: acknowledge every read byte but the last
							if (bit_ff == ifmt_pkg::ACK_SLOT) begin
								nxt_sda_oe = !is_wr && !is_last;
							end else begin
								nxt_sda_oe = is_wr && !sh_ff[7];
							end
						end
						2'h1: nxt_scl_oe = 1'b0;
						2'h2: begin
							if (bit_ff != ifmt_pkg::ACK_SLOT) begin
								nxt_sh = {sh_ff[6:0], sda_s2_ff};
							end else begin
								nxt_nacked = is_wr && sda_s2_ff;
							end
						end
						default: begin
							nxt_scl_oe = 1'b1;
							nxt_bit    = bit_ff + 4'h1;
							if (bit_ff == ifmt_pkg::ACK_SLOT) begin
								nxt_bit  = 4'h0;
								nxt_byte = byte_ff + 9'h001;
								if (!is_wr && kind_ff == ifmt_pkg::KIND_RDH
									&& byte_ff == 9'(ifmt_pkg::HDR_BYTES)) begin
									nxt_rlen = sh_ff;
								end
								if (!is_wr && kind_ff == ifmt_pkg::KIND_RDP) begin
									nxt_rd_data  = sh_ff;
									nxt_rd_valid = 1'b1;
								end
								if (nacked_ff) begin
									nxt_nack  = 1'b1;
									nxt_state = ifmt_pkg::M_STOP;
								end else if (is_last) begin
									nxt_state = ifmt_pkg::M_STOP;
									if (kind_ff == ifmt_pkg::KIND_RDH) begin
										nxt_pend = sh_ff >= ifmt_pkg::LEN_MIN;
									end else if (kind_ff == ifmt_pkg::KIND_RDP) begin
										nxt_pend    = 1'b0;
										nxt_booted  = 1'b1;
										nxt_rd_done = 1'b1;
									end
								end else if (kind_ff == ifmt_pkg::KIND_WR) begin
									if (byte_ff == 9'h000) begin
										nxt_sh = ifmt_pkg::FRAME_MARKER;
									end else if (byte_ff == 9'h001) begin
										nxt_sh = wlen_ff;
									end else begin
										nxt_sh   = WR_DATA;
										nxt_take = 1'b1;
									end
								end
							end
						end
					endcase
				end
			end
			ifmt_pkg::M_STOP: begin
				// two rounds of quarters leave the bus free long enough for the
				// target to drop attention before it is looked at again
				// only the first round pulls sda, a second pull would be a stray start
				if (tick) begin
					nxt_q = q_ff + 2'h1;
					case (q_ff)
						2'h0: nxt_sda_oe = (bit_ff == 4'h0);
						2'h1: nxt_scl_oe = 1'b0;
						2'h2: nxt_sda_oe = 1'b0;
						default: begin
							nxt_bit = bit_ff + 4'h1;
							if (bit_ff[1:0] == ifmt_pkg::STOP_ROUNDS) begin
								nxt_state = ifmt_pkg::M_IDLE;
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff    <= ifmt_pkg::M_IDLE;
			kind_ff     <= ifmt_pkg::KIND_RDH;
			div_ff      <= 8'h00;
			q_ff        <= 2'h0;
			bit_ff      <= 4'h0;
			byte_ff     <= 9'h000;
			sh_ff       <= 8'h00;
			sda_oe_ff   <= 1'b0;
			scl_oe_ff   <= 1'b0;
			wlen_ff     <= 8'h00;
			rlen_ff     <= 8'h00;
			nacked_ff   <= 1'b0;
			pend_ff     <= 1'b0;
			booted_ff   <= 1'b0;
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
			rd_done_ff  <= 1'b0;
			nack_ff     <= 1'b0;
			take_ff     <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			kind_ff     <= nxt_kind;
			div_ff      <= nxt_div;
			q_ff        <= nxt_q;
			bit_ff      <= nxt_bit;
			byte_ff     <= nxt_byte;
			sh_ff       <= nxt_sh;
			sda_oe_ff   <= nxt_sda_oe;
			scl_oe_ff   <= nxt_scl_oe;
			wlen_ff     <= nxt_wlen;
			rlen_ff     <= nxt_rlen;
			nacked_ff   <= nxt_nacked;
			pend_ff     <= nxt_pend;
			booted_ff   <= nxt_booted;
			rd_data_ff  <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			rd_done_ff  <= nxt_rd_done;
			nack_ff     <= nxt_nack;
			take_ff     <= nxt_take;
		end
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign LINK.m_scl_o  = 1'b0;
	assign LINK.m_scl_oe = scl_oe_ff;
	assign LINK.m_sda_o  = 1'b0;
	assign LINK.m_sda_oe = sda_oe_ff;
	assign WR_TAKE       = take_ff;
	assign READY         = ready;
	assign RD_DATA       = rd_data_ff;
	assign RD_VALID      = rd_valid_ff;
	assign RD_LEN        = rlen_ff;
	assign RD_DONE       = rd_done_ff;
	assign NACK_ERR      = nack_ff;
	assign BOOTED        = booted_ff;
endmodule

// ---- rtl/ifmt_pkg.sv ----
// shared constants and types for the framed message transport over i2c
package ifmt_pkg;
	// ----------------------------------------------------------------
	// addressing and frame layout
	// ----------------------------------------------------------------
	localparam logic [6:0] TGT_ADDR      = 7'h50;
	localparam logic [7:0] ADDR_WR       = 8'ha0;
	localparam logic [7:0] ADDR_RD       = 8'ha1;
	localparam logic [7:0] FRAME_MARKER  = 8'hee;
	localparam logic [7:0] LEN_MIN       = 8'h01;
	localparam logic [7:0] IDLE_BYTE     = 8'hff;
	localparam int         HDR_BYTES     = 2;
	localparam logic [3:0] ACK_SLOT      = 4'h8;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLK_PERIOD_NS = 4;
	localparam int         SCL_PERIOD_NS = 48;
	localparam int         SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [1:0] STOP_ROUNDS   = 2'h1;
	// ----------------------------------------------------------------
	// state encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		T_IDLE = 3'h0,
		T_ADDR = 3'h1,
		T_AACK = 3'h3,
		T_WR   = 3'h2,
		T_WACK = 3'h6,
		T_RD   = 3'h7,
		T_RACK = 3'h5
	} ifmt_tstate_t;
	typedef enum logic [1:0] {
		M_IDLE  = 2'h0,
		M_START = 2'h1,
		M_BYTE  = 2'h3,
		M_STOP  = 2'h2
	} ifmt_mstate_t;
	typedef enum logic [1:0] {
		KIND_WR  = 2'h0,
		KIND_RDH = 2'h1,
		KIND_RDP = 2'h3
	} ifmt_kind_t;
endpackage

// ---- rtl/ifmt_link_if.sv ----
// open-drain i2c link plus the attention line between the two ends
`timescale 1ns/1ps
interface ifmt_link_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic t_scl_o;
	logic t_scl_oe;
	logic t_sda_o;
	logic t_sda_oe;
	logic host_attention_line;
	logic scl;
	logic sda;
	// wired-and with pull-up: a line is low while any enabled driver drives low
	assign scl = !((m_scl_oe && !m_scl_o) || (t_scl_oe && !t_scl_o));
	assign sda = !((m_sda_oe && !m_sda_o) || (t_sda_oe && !t_sda_o));
	modport target (input scl, input sda, output t_scl_o, output t_scl_oe,
		output t_sda_o, output t_sda_oe, output host_attention_line);
	modport host (input scl, input sda, input host_attention_line,
		output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface

// ---- rtl/ifmt_target.sv ----
// device end: i2c target that receives and serves framed messages
`timescale 1ns/1ps
module ifmt_target #(
	parameter int DEPTH = 255
) (
	// system
	input  wire logic       CLK_SYS,
	input  wire logic       RESET_N,
	// link
	ifmt_link_if.target     LINK,
	// outgoing frame load
	input  wire logic       TX_WE,
	input  wire logic [7:0] TX_ADDR,
	input  wire logic [7:0] TX_DATA,
	input  wire logic       TX_SEND,
	input  wire logic [7:0] TX_LEN,
	output logic            TX_PENDING,
	// incoming frame
	output logic [7:0]      RX_DATA,
	output logic            RX_VALID,
	output logic [7:0]      RX_LEN,
	output logic            RX_DONE,
	output logic            RX_ERR
);
	// ----------------------------------------------------------------
	// pin synchronisers and bus events
	// ----------------------------------------------------------------
	logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
	logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			{scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
			{sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
		end else begin
			{scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {LINK.scl, scl_s1_ff, scl_s2_ff};
			{sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {LINK.sda, sda_s1_ff, sda_s2_ff};
		end
	end
	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise  = scl_s2_ff && !scl_s3_ff;
	assign scl_fall  = !scl_s2_ff && scl_s3_ff;
	assign bus_start = scl_s2_ff && scl_s3_ff && sda_s3_ff && !sda_s2_ff;
	assign bus_stop  = scl_s2_ff && scl_s3_ff && !sda_s3_ff && sda_s2_ff;
	// ----------------------------------------------------------------
	// outgoing frame store
	// ----------------------------------------------------------------
	logic [7:0] mem [0:DEPTH-1];
	always_ff @(posedge CLK_SYS) begin
		if (TX_WE) begin
			mem[TX_ADDR] <= TX_DATA;
		end
	end
	// ----------------------------------------------------------------
	// protocol engine
	// ----------------------------------------------------------------
	ifmt_pkg::ifmt_tstate_t state_ff, nxt_state;
	logic [3:0] bit_ff, nxt_bit;
	logic [7:0] sh_ff, nxt_sh;
	logic       oe_ff, nxt_oe;
	logic       rd_act_ff, nxt_rd_act;
	logic       wr_act_ff, nxt_wr_act;
	logic [8:0] idx_ff, nxt_idx;
	logic       stage_ff, nxt_stage;
	logic       attn_ff, nxt_attn;
	logic [7:0] len_ff, nxt_len;
	logic [8:0] wc_ff, nxt_wc;
	logic [7:0] rlen_ff, nxt_rlen;
	logic       err_ff, nxt_err;
	logic [7:0] rx_data_ff, nxt_rx_data;
	logic       rx_valid_ff, nxt_rx_valid;
	logic       rx_done_ff, nxt_rx_done;
	logic       rx_err_ff, nxt_rx_err;

	// header bytes come from the engine itself, payload from the store
	function automatic logic [7:0] tx_byte(input logic [8:0] i);
		if (!stage_ff) begin
			tx_byte = (i == 9'h000) ? ifmt_pkg::FRAME_MARKER :
				((i == 9'h001) ? len_ff : ifmt_pkg::IDLE_BYTE);
		end else begin
			tx_byte = (i < {1'b0, len_ff}) ? mem[i[7:0]] : ifmt_pkg::IDLE_BYTE;
		end
	endfunction

	always_comb begin
		logic [7:0] b;
		b            = tx_byte(idx_ff);
		nxt_state    = state_ff;
		nxt_bit      = bit_ff;
		nxt_sh       = sh_ff;
		nxt_oe       = oe_ff;
		nxt_rd_act   = rd_act_ff;
		nxt_wr_act   = wr_act_ff;
		nxt_idx      = idx_ff;
		nxt_stage    = stage_ff;
		nxt_attn     = attn_ff;
		nxt_len      = len_ff;
		nxt_wc       = wc_ff;
		nxt_rlen     = rlen_ff;
		nxt_err      = err_ff;
		nxt_rx_data  = rx_data_ff;
		nxt_rx_valid = 1'b0;
		nxt_rx_done  = 1'b0;
		nxt_rx_err   = 1'b0;
		if (bus_start || bus_stop) begin
			if (rd_act_ff && !stage_ff && idx_ff >= 9'(ifmt_pkg::HDR_BYTES)) begin
				nxt_stage = 1'b1;
			end
			if (rd_act_ff && stage_ff && idx_ff >= {1'b0, len_ff}) begin
				nxt_stage = 1'b0;
				nxt_attn  = 1'b0;
			end
			if (wr_act_ff) begin
				// a frame is good only if its length byte matched what arrived
				if (!err_ff && wc_ff == {1'b0, rlen_ff} + 9'(ifmt_pkg::HDR_BYTES)) begin
					nxt_rx_done = 1'b1;
				end else begin
					nxt_rx_err = 1'b1;
				end
			end
			nxt_rd_act = 1'b0;
			nxt_wr_act = 1'b0;
			nxt_oe     = 1'b0;
			nxt_bit    = 4'h0;
			nxt_state  = bus_start ? ifmt_pkg::T_ADDR : ifmt_pkg::T_IDLE;
		end else begin
			unique case (state_ff)
				ifmt_pkg::T_IDLE: begin
				end
				ifmt_pkg::T_ADDR: begin
					if (scl_rise) begin
						nxt_sh  = {sh_ff[6:0], sda_s2_ff};
						nxt_bit = bit_ff + 4'h1;
					end else if (scl_fall && bit_ff == ifmt_pkg::ACK_SLOT) begin
						// writes are refused while a frame waits for the host
						if (sh_ff[7:1] == ifmt_pkg::TGT_ADDR && !(!sh_ff[0] && attn_ff)) begin
							nxt_state  = ifmt_pkg::T_AACK;
							nxt_oe     = 1'b1;
							nxt_rd_act = sh_ff[0];
							nxt_wr_act = !sh_ff[0];
							nxt_idx    = 9'h000;
							nxt_wc     = 9'h000;
							nxt_err    = 1'b0;
						end else begin
							nxt_state = ifmt_pkg::T_IDLE;
						end
					end
				end
				ifmt_pkg::T_AACK, ifmt_pkg::T_RACK: begin
					if (state_ff == ifmt_pkg::T_RACK && scl_rise && sda_s2_ff) begin
						nxt_state = ifmt_pkg::T_IDLE;
					end else if (scl_fall && rd_act_ff) begin
						nxt_oe    = !b[7];
						nxt_sh    = {b[6:0], 1'b0};
						nxt_bit   = 4'h1;
						nxt_idx   = idx_ff + 9'h001;
						nxt_state = ifmt_pkg::T_RD;
					end else if (scl_fall) begin
						nxt_oe    = 1'b0;
						nxt_bit   = 4'h0;
						nxt_state = ifmt_pkg::T_WR;
					end
				end
				ifmt_pkg::T_WR: begin
					if (scl_rise) begin
						nxt_sh  = {sh_ff[6:0], sda_s2_ff};
						nxt_bit = bit_ff + 4'h1;
					end else if (scl_fall && bit_ff == ifmt_pkg::ACK_SLOT) begin
						nxt_oe    = 1'b1;
						nxt_state = ifmt_pkg::T_WACK;
						if (wc_ff != 9'h1ff) begin
							nxt_wc = wc_ff + 9'h001;
						end
						if (wc_ff == 9'h000) begin
							nxt_err = err_ff || sh_ff != ifmt_pkg::FRAME_MARKER;
						end else if (wc_ff == 9'h001) begin
							nxt_rlen = sh_ff;
							nxt_err  = err_ff || sh_ff < ifmt_pkg::LEN_MIN;
						end else if (wc_ff < {1'b0, rlen_ff} + 9'(ifmt_pkg::HDR_BYTES)) begin
							nxt_rx_data  = sh_ff;
							nxt_rx_valid = !err_ff;
						end else begin
							nxt_err = 1'b1;
						end
					end
				end
				ifmt_pkg::T_WACK: begin
					if (scl_fall) begin
						nxt_oe    = 1'b0;
						nxt_bit   = 4'h0;
						nxt_state = ifmt_pkg::T_WR;
					end
				end
				ifmt_pkg::T_RD: begin
					if (scl_fall && bit_ff == ifmt_pkg::ACK_SLOT) begin
						nxt_oe    = 1'b0;
						nxt_state = ifmt_pkg::T_RACK;
					end else if (scl_fall) begin
						nxt_oe  = !sh_ff[7];
						nxt_sh  = {sh_ff[6:0], 1'b0};
						nxt_bit = bit_ff + 4'h1;
					end
				end
				default: begin
					nxt_oe    = 1'b0;
					nxt_state = ifmt_pkg::T_IDLE;
				end
			endcase
		end
		// a new frame is only taken once the previous one has been fetched
		if (TX_SEND && !attn_ff && TX_LEN >= ifmt_pkg::LEN_MIN) begin
			nxt_attn = 1'b1;
			nxt_len  = TX_LEN;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff    <= ifmt_pkg::T_IDLE;
			bit_ff      <= 4'h0;
			sh_ff       <= 8'h00;
			oe_ff       <= 1'b0;
			rd_act_ff   <= 1'b0;
			wr_act_ff   <= 1'b0;
			idx_ff      <= 9'h000;
			stage_ff    <= 1'b0;
			attn_ff     <= 1'b0;
			len_ff      <= 8'h00;
			wc_ff       <= 9'h000;
			rlen_ff     <= 8'h00;
			err_ff      <= 1'b0;
			rx_data_ff  <= 8'h00;
			rx_valid_ff <= 1'b0;
			rx_done_ff  <= 1'b0;
			rx_err_ff   <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			bit_ff      <= nxt_bit;
			sh_ff       <= nxt_sh;
			oe_ff       <= nxt_oe;
			rd_act_ff   <= nxt_rd_act;
			wr_act_ff   <= nxt_wr_act;
			idx_ff      <= nxt_idx;
			stage_ff    <= nxt_stage;
			attn_ff     <= nxt_attn;
			len_ff      <= nxt_len;
			wc_ff       <= nxt_wc;
			rlen_ff     <= nxt_rlen;
			err_ff      <= nxt_err;
			rx_data_ff  <= nxt_rx_data;
			rx_valid_ff <= nxt_rx_valid;
			rx_done_ff  <= nxt_rx_done;
			rx_err_ff   <= nxt_rx_err;
		end
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign LINK.t_sda_o              = 1'b0;
	assign LINK.t_sda_oe             = oe_ff;
	assign LINK.t_scl_o              = 1'b0;
	assign LINK.t_scl_oe             = 1'b0;
	assign LINK.host_attention_line  = attn_ff;
	assign TX_PENDING                = attn_ff;
	assign RX_DATA                   = rx_data_ff;
	assign RX_VALID                  = rx_valid_ff;
	assign RX_LEN                    = rlen_ff;
	assign RX_DONE                   = rx_done_ff;
	assign RX_ERR                    = rx_err_ff;
endmodule

// ---- bench/ifmt_chk.sv ----
// link checker for the framed transport, watching the shared wires
`timescale 1ns/1ps
module ifmt_chk (
	// system
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic t_sda_oe,
	input wire logic host_attention_line
);
	logic       scl_ff, sda_ff, hdr_ff, nxt_hdr;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [1:0] byte_ff, nxt_byte, kind_ff, nxt_kind;
	logic [7:0] sh_ff, nxt_sh;
	logic       rise, start, adr9, dat9;
	// -----------
	// bit and byte tracking
	// -----------
	assign rise  = scl && !scl_ff;
	assign start = scl && scl_ff && sda_ff && !sda;
	assign adr9  = rise && cnt_ff == 4'h8 && byte_ff == 2'h0;
	assign dat9  = rise && cnt_ff == 4'h8 && (kind_ff == 2'h1 || kind_ff == 2'h2);
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_byte = byte_ff;
		nxt_sh   = sh_ff;
		nxt_kind = kind_ff;
		nxt_hdr  = hdr_ff;
		if (rise) begin
			nxt_cnt = (cnt_ff == 4'h9) ? 4'h1 : cnt_ff + 4'h1;
			nxt_sh  = {sh_ff[6:0], sda};
			// saturate so long payloads never alias the address byte
			if (cnt_ff == 4'h9 && byte_ff != 2'h3)
				nxt_byte = byte_ff + 2'h1;
		end
		if (adr9 && sh_ff == ifmt_pkg::ADDR_WR)
			nxt_kind = 2'h1;
		if (adr9 && sh_ff == ifmt_pkg::ADDR_RD && !sda) begin
			nxt_kind = hdr_ff ? 2'h2 : 2'h3;
			nxt_hdr  = !hdr_ff;
		end
		if (!host_attention_line)
			nxt_hdr = 1'b1;
		if (start) begin
			nxt_cnt  = 4'h0;
			nxt_byte = 2'h0;
			nxt_kind = 2'h0;
		end
	end
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			{scl_ff, sda_ff, hdr_ff} <= 3'h7;
			{cnt_ff, byte_ff, kind_ff, sh_ff} <= 16'h0000;
		end else begin
			{scl_ff, sda_ff, hdr_ff} <= {scl, sda, nxt_hdr};
			{cnt_ff, byte_ff, kind_ff, sh_ff} <= {nxt_cnt, nxt_byte, nxt_kind, nxt_sh};
		end
	end
	// -----------
	// properties
	// -----------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	AST_ADDR_MATCH: assert property (adr9 && !sda |-> sh_ff[7:1] == ifmt_pkg::TGT_ADDR)
		else $error("ack on foreign address");
	AST_DIR_BIT: assert property (adr9 && !sda |->
		sh_ff == ifmt_pkg::ADDR_WR || sh_ff == ifmt_pkg::ADDR_RD)
		else $error("bad direction byte acked");
	AST_TGT_HOLD: assert property (scl && scl_ff |-> $stable(t_sda_oe))
		else $error("target moved sda while scl high");
	AST_MARKER: assert property (dat9 && byte_ff == 2'h1 |->
		sh_ff == ifmt_pkg::FRAME_MARKER)
		else $error("first frame byte is not the marker");
	AST_LEN_MIN: assert property (dat9 && byte_ff == 2'h2 |->
		sh_ff >= ifmt_pkg::LEN_MIN)
		else $error("length byte below one");
	AST_WR_REFUSED: assert property (adr9 && sh_ff == ifmt_pkg::ADDR_WR &&
		host_attention_line |-> sda)
		else $error("write acked while attention high");
	AST_HDR_END: assert property (dat9 && kind_ff == 2'h2 && byte_ff == 2'h2 |-> sda)
		else $error("header read not ended after two bytes");
	AST_HDR_TWO: assert property (rise && kind_ff == 2'h2 |-> byte_ff != 2'h3)
		else $error("header read ran past two bytes");
	AST_ATT_HOLD: assert property (kind_ff == 2'h2 && !start |=> host_attention_line)
		else $error("attention lost before payload read");
	AST_ATT_DROP: assert property ($fell(host_attention_line) |-> scl && sda)
		else $error("attention dropped with bus busy");
	cover property (adr9 && sh_ff == ifmt_pkg::ADDR_WR && !sda);
	cover property (rise && kind_ff == 2'h2);
	cover property ($fell(host_attention_line));
endmodule

// ---- bench/test_i2c_framed_message_transport.sv ----
// bench joining host end and device end over one link
`timescale 1ns/1ps
module test_i2c_framed_message_transport;
	logic       clk_sys, reset_n, tx_we, tx_send, wr_start;
	logic [7:0] tx_addr, tx_data, tx_len, wr_len, wr_data;
	logic       tx_pending, rx_valid, rx_done, rx_err, wr_take, ready;
	logic       rd_valid, rd_done, nack_err, booted;
	logic [7:0] rx_data, rx_len, rd_data, rd_len;
	int         bad_count, tests_run;
	ifmt_link_if ifmt_link_if_i ();
	ifmt_target ifmt_target_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(ifmt_link_if_i),
		.TX_WE(tx_we), .TX_ADDR(tx_addr), .TX_DATA(tx_data), .TX_SEND(tx_send),
		.TX_LEN(tx_len), .TX_PENDING(tx_pending), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_LEN(rx_len), .RX_DONE(rx_done), .RX_ERR(rx_err));
	ifmt_master ifmt_master_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(ifmt_link_if_i),
		.WR_START(wr_start), .WR_LEN(wr_len), .WR_DATA(wr_data), .WR_TAKE(wr_take),
		.READY(ready), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_LEN(rd_len),
		.RD_DONE(rd_done), .NACK_ERR(nack_err), .BOOTED(booted));
	ifmt_chk ifmt_chk_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .scl(ifmt_link_if_i.scl),
		.sda(ifmt_link_if_i.sda), .t_sda_oe(ifmt_link_if_i.t_sda_oe),
		.host_attention_line(ifmt_link_if_i.host_attention_line));
	// -----------
	// helpers
	// -----------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// device user queues a frame of base+i payload bytes
	task automatic load(input int len, input logic [7:0] base);
		for (int i = 0; i < len; i++) begin
			{tx_we, tx_addr, tx_data} = {1'b1, 8'(i), base + 8'(i)};
			@(negedge clk_sys);
		end
		{tx_we, tx_send, tx_len} = {2'b01, 8'(len)};
		@(negedge clk_sys);
		tx_send = 1'b0;
		chk("tx_pending", 8'h01, {7'h0, tx_pending});
	endtask
	// one write and/or one fetched frame, judged byte by byte
	task automatic xfer(input int wlen, input int rlen, input int rxn, input logic [7:0] base);
		int n;
		int wi;
		int ri;
		int xi;
		int dn;
		{wi, ri, xi, dn} = '0;
		if (wlen > 0) begin
			{wr_len, wr_data, wr_start} = {8'(wlen), base, 1'b1};
			@(negedge clk_sys);
			wr_start = 1'b0;
		end
		for (n = 0; n < 8000 && (xi < rxn || ri < rlen || (rlen > 0 && rd_done !== 1'b1)); n++) begin
			@(negedge clk_sys);
			if (wr_take === 1'b1) begin
				wi++;
				wr_data = base + 8'(wi);
			end
			if (rx_valid === 1'b1) begin
				chk("rx_data", base + 8'(xi), rx_data);
				xi++;
			end
			if (rd_valid === 1'b1) begin
				chk("rd_data", base + 8'(ri), rd_data);
				ri++;
			end
			if (rx_err !== 1'b0 || nack_err !== 1'b0)
				chk("error pulse", 8'h00, 8'h01);
		end
		// the frame verdict only comes after the stop, so keep watching it here
		for (int k = 0; k < 400 && ready !== 1'b1; k++) begin
			@(negedge clk_sys);
			if (rx_done === 1'b1)
				dn++;
			if (rx_err !== 1'b0 || nack_err !== 1'b0)
				chk("late error pulse", 8'h00, 8'h01);
		end
		if (n >= 8000 || ready !== 1'b1) begin
			bad_count++;
			wrap_up();
		end
		chk("rx_count", 8'(rxn), 8'(xi));
		chk("rx_done", {7'h0, rxn > 0}, 8'(dn));
		chk("rd_count", 8'(rlen), 8'(ri));
		chk("attention", 8'h00, {7'h0, tx_pending});
		if (wlen > 0 && rxn > 0)
			chk("rx_len", 8'(wlen), rx_len);
		if (rlen > 0)
			chk("rd_len", 8'(rlen), rd_len);
	endtask
	// -----------
	// scenarios
	// -----------
	task automatic t_boot();
		chk("ready before boot", 8'h00, {7'h0, ready});
		{tx_send, tx_len} = {1'b1, 8'h00};
		@(negedge clk_sys);
		tx_send = 1'b0;
		chk("zero length refused", 8'h00, {7'h0, tx_pending});
		load(1, 8'hb0);
		xfer(0, 1, 0, 8'hb0);
		chk("booted", 8'h01, {7'h0, booted});
		$display("boot frame fetched");
	endtask
	task automatic t_write();
		xfer(1, 0, 1, 8'h10);
		xfer(3, 0, 3, 8'h20);
		xfer(9, 0, 9, 8'h30);
		$display("writes delivered");
	endtask
	// attention rising while the host sends its start, before the address byte, makes the device refuse the write
	task automatic t_race();
		int n;
		{wr_len, wr_data, wr_start} = {8'h01, 8'h55, 1'b1};
		@(negedge clk_sys);
		wr_start = 1'b0;
		load(2, 8'hd0);
		for (n = 0; n < 400 && nack_err !== 1'b1; n++)
			@(negedge clk_sys);
		chk("write refused", 8'h01, {7'h0, nack_err});
		xfer(0, 2, 0, 8'hd0);
		$display("write refused during attention");
	endtask
	// a pending frame blocks host writes until it is fetched
	task automatic t_blocked();
		load(4, 8'hc0);
		repeat (3) @(negedge clk_sys);
		chk("ready while pending", 8'h00, {7'h0, ready});
		xfer(2, 4, 0, 8'hc0);
		$display("write held off during attention");
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = !clk_sys;
	end
	initial begin
		{bad_count, tests_run} = '0;
		{reset_n, tx_we, tx_send, wr_start, tx_addr, tx_data, tx_len, wr_len, wr_data} = '0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		t_boot();
		t_write();
		t_race();
		t_blocked();
		wrap_up();
	end
endmodule
